// ==== logic/dual_comparator_control.sv ====
// Purpose: Control and status logic of a dual comparator with timer gating
// Assumes: Comparator outputs, timer clock and gate pin are asynchronous levels
// Notes: Zero-wait AHB-Lite slave; gate output is high while the timer may count
`default_nettype none

module dual_comparator_control (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic ce,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Analog side: raw outputs are 1 while plus input is above minus input
	input wire logic first_cmp_raw,
	input wire logic second_cmp_raw,
	output logic [2:0] cmp_mode_field,
	output logic input_switch_sel,
	output logic cmp_enable,
	output logic cmp_pins_analog,
	output logic first_cmp_output,
	output logic second_cmp_output,
	// Timer gate side
	input wire logic timer_clk,
	input wire logic external_gate_pin,
	input wire logic timer_on,
	input wire logic gate_enable,
	output logic timer_count_enable,
	output logic timer_gate_source_sel,
	output logic cmp_output_sync
);

	// ****************************************
	// Decode functions
	// ****************************************
	function automatic cmp_ctrl_pkg::reg_sel_t decode_addr(input logic [31:0] addr);
		if (addr == cmp_ctrl_pkg::CONFIG_OFFSET) begin
			return cmp_ctrl_pkg::sel_config_t;
		end else if (addr == cmp_ctrl_pkg::TIMER_CFG_OFFSET) begin
			return cmp_ctrl_pkg::sel_timer_cfg_t;
		end else begin
			return cmp_ctrl_pkg::sel_none_t;
		end
	endfunction

	function automatic logic polarity(input logic on, input logic raw, input logic inv);
		return on && (raw ^ inv);
	endfunction

	// ****************************************
	// Input synchronisers
	// ****************************************
	logic [3:0] async_levels;
	logic [3:0] sync_levels;
	logic first_raw_s;
	logic second_raw_s;
	logic timer_clk_s;
	logic gate_pin_s;

	assign async_levels = {external_gate_pin, timer_clk, second_cmp_raw, first_cmp_raw};

	level_sync #(
		.WIDTH(4)
	) u_sync (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.ce(ce),
		.async_in(async_levels),
		.sync_out(sync_levels)
	);

	assign first_raw_s = sync_levels[0];
	assign second_raw_s = sync_levels[1];
	assign timer_clk_s = sync_levels[2];
	assign gate_pin_s = sync_levels[3];

	// ****************************************
	// Configuration state
	// ****************************************
	logic first_cmp_invert;
	logic second_cmp_invert;
	logic [2:0] mode;
	logic in_switch;
	logic gate_sel;
	logic sync_en;

	// ****************************************
	// Bus address phase capture
	// ****************************************
	logic wr_pending;
	cmp_ctrl_pkg::reg_sel_t wr_sel;
	logic addr_valid;
	logic wr_config;
	logic wr_timer_cfg;

	assign addr_valid = hsel && hready &&
		(htrans == cmp_ctrl_pkg::HTRANS_NONSEQ || htrans == cmp_ctrl_pkg::HTRANS_SEQ);

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			wr_pending <= 1'b0;
			wr_sel <= cmp_ctrl_pkg::sel_none_t;
		end else if (ce) begin
			wr_pending <= addr_valid && hwrite;
			wr_sel <= decode_addr(haddr);
		end
	end

	assign wr_config = wr_pending && (wr_sel == cmp_ctrl_pkg::sel_config_t);
	assign wr_timer_cfg = wr_pending && (wr_sel == cmp_ctrl_pkg::sel_timer_cfg_t);

	// ****************************************
	// Register writes
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			second_cmp_invert <= cmp_ctrl_pkg::CONFIG_RESET[cmp_ctrl_pkg::SECOND_INV_BIT];
			first_cmp_invert <= cmp_ctrl_pkg::CONFIG_RESET[cmp_ctrl_pkg::FIRST_INV_BIT];
			in_switch <= cmp_ctrl_pkg::CONFIG_RESET[cmp_ctrl_pkg::INPUT_SWITCH_BIT];
			mode <= cmp_ctrl_pkg::CONFIG_RESET[cmp_ctrl_pkg::MODE_LSB +: cmp_ctrl_pkg::MODE_WIDTH];
		end else if (ce && wr_config) begin
			second_cmp_invert <= hwdata[cmp_ctrl_pkg::SECOND_INV_BIT];
			first_cmp_invert <= hwdata[cmp_ctrl_pkg::FIRST_INV_BIT];
			in_switch <= hwdata[cmp_ctrl_pkg::INPUT_SWITCH_BIT];
			mode <= hwdata[cmp_ctrl_pkg::MODE_LSB +: cmp_ctrl_pkg::MODE_WIDTH];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			gate_sel <= cmp_ctrl_pkg::GATE_SEL_RESET;
			sync_en <= cmp_ctrl_pkg::SYNC_RESET;
		end else if (ce && wr_timer_cfg) begin
			gate_sel <= hwdata[cmp_ctrl_pkg::GATE_SEL_BIT];
			sync_en <= hwdata[cmp_ctrl_pkg::SYNC_BIT];
		end
	end

	// ****************************************
	// Comparator outputs with polarity
	// ****************************************
	logic cmps_on;
	logic next_first_out;
	logic next_second_out;

	assign cmps_on = (mode != cmp_ctrl_pkg::MODE_OFF);
	assign next_first_out = polarity(cmps_on, first_raw_s, first_cmp_invert);
	assign next_second_out = polarity(cmps_on, second_raw_s, second_cmp_invert);

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			first_cmp_output <= 1'b0;
			second_cmp_output <= 1'b0;
		end else if (ce) begin
			first_cmp_output <= next_first_out;
			second_cmp_output <= next_second_out;
		end
	end

	// ****************************************
	// Mode and pin configuration
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			cmp_mode_field <=
				cmp_ctrl_pkg::CONFIG_RESET[cmp_ctrl_pkg::MODE_LSB +: cmp_ctrl_pkg::MODE_WIDTH];
			input_switch_sel <= cmp_ctrl_pkg::CONFIG_RESET[cmp_ctrl_pkg::INPUT_SWITCH_BIT];
			cmp_enable <= 1'b1;
			cmp_pins_analog <= 1'b1;
		end else if (ce) begin
			cmp_mode_field <= mode;
			input_switch_sel <= in_switch;
			cmp_enable <= cmps_on;
			cmp_pins_analog <= cmps_on;
		end
	end

	// ****************************************
	// Timer clock falling edge latch
	// ****************************************
	logic timer_clk_d;
	logic timer_clk_fall;
	logic latched_second;

	assign timer_clk_fall = timer_clk_d && !timer_clk_s;

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			timer_clk_d <= 1'b0;
			latched_second <= 1'b0;
		end else if (ce) begin
			timer_clk_d <= timer_clk_s;
			if (timer_clk_fall) begin
				latched_second <= next_second_out;
			end
		end
	end

	// ****************************************
	// Timer gate selection
	// ****************************************
	logic cmp_gate;
	logic next_count_enable;

	// Software is expected to set sync_en while the comparator gates the timer
	assign cmp_gate = sync_en ? latched_second : next_second_out;

	always_comb begin
		if (!(timer_on && gate_enable)) begin
			next_count_enable = timer_on;
		end else if (gate_sel) begin
			next_count_enable = gate_pin_s;
		end else begin
			next_count_enable = cmp_gate;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			timer_count_enable <= 1'b0;
			timer_gate_source_sel <= cmp_ctrl_pkg::GATE_SEL_RESET;
			cmp_output_sync <= cmp_ctrl_pkg::SYNC_RESET;
		end else if (ce) begin
			timer_count_enable <= next_count_enable;
			timer_gate_source_sel <= gate_sel;
			cmp_output_sync <= sync_en;
		end
	end

	// ****************************************
	// Register view seen by a read
	// ****************************************
	logic [7:0] config_view;
	logic [1:0] timer_cfg_view;

	// A write still in its data phase is forwarded so a back-to-back read sees it
	always_comb begin
		config_view = 8'h00;
		config_view[cmp_ctrl_pkg::SECOND_OUT_BIT] = next_second_out;
		config_view[cmp_ctrl_pkg::FIRST_OUT_BIT] = next_first_out;
		if (wr_config) begin
			config_view[cmp_ctrl_pkg::SECOND_INV_BIT] = hwdata[cmp_ctrl_pkg::SECOND_INV_BIT];
			config_view[cmp_ctrl_pkg::FIRST_INV_BIT] = hwdata[cmp_ctrl_pkg::FIRST_INV_BIT];
			config_view[cmp_ctrl_pkg::INPUT_SWITCH_BIT] = hwdata[cmp_ctrl_pkg::INPUT_SWITCH_BIT];
			config_view[cmp_ctrl_pkg::MODE_LSB +: cmp_ctrl_pkg::MODE_WIDTH] =
				hwdata[cmp_ctrl_pkg::MODE_LSB +: cmp_ctrl_pkg::MODE_WIDTH];
		end else begin
			config_view[cmp_ctrl_pkg::SECOND_INV_BIT] = second_cmp_invert;
			config_view[cmp_ctrl_pkg::FIRST_INV_BIT] = first_cmp_invert;
			config_view[cmp_ctrl_pkg::INPUT_SWITCH_BIT] = in_switch;
			config_view[cmp_ctrl_pkg::MODE_LSB +: cmp_ctrl_pkg::MODE_WIDTH] = mode;
		end
	end

	always_comb begin
		timer_cfg_view = 2'h0;
		if (wr_timer_cfg) begin
			timer_cfg_view[cmp_ctrl_pkg::GATE_SEL_BIT] = hwdata[cmp_ctrl_pkg::GATE_SEL_BIT];
			timer_cfg_view[cmp_ctrl_pkg::SYNC_BIT] = hwdata[cmp_ctrl_pkg::SYNC_BIT];
		end else begin
			timer_cfg_view[cmp_ctrl_pkg::GATE_SEL_BIT] = gate_sel;
			timer_cfg_view[cmp_ctrl_pkg::SYNC_BIT] = sync_en;
		end
	end

	// ****************************************
	// Read data and response
	// ****************************************
	logic [31:0] next_rdata;

	always_comb begin
		next_rdata = 32'h0000_0000;
		case (decode_addr(haddr))
			cmp_ctrl_pkg::sel_config_t: begin
				next_rdata = {24'h00_0000, config_view};
			end
			cmp_ctrl_pkg::sel_timer_cfg_t: begin
				next_rdata = {30'h0, timer_cfg_view};
			end
			default: begin
				next_rdata = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= cmp_ctrl_pkg::HRESP_OKAY;
		end else if (ce) begin
			if (addr_valid && !hwrite) begin
				hrdata <= next_rdata;
			end
			hreadyout <= 1'b1;
			hresp <= cmp_ctrl_pkg::HRESP_OKAY;
		end
	end

endmodule

`default_nettype wire

// ==== logic/cmp_ctrl_pkg.sv ====
// Purpose: Shared constants of the dual comparator control block
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register
// Notes: Offsets are byte addresses of aligned 32-bit words
// Contract
// - Second output bit is 1 when its plus input is higher, if not inverted.
// - First output bit is 1 when its plus input is lower, if inverted.
// - Config holds two read-only outputs, two inverts, input switch, mode; resets zero.
// - Gate select cleared lets the second comparator output gate the timer.
// - Comparator gating acts only while timer is on and gating is enabled.
// - Sync set latches comparator output on timer clock falling edge.
// - Gate select set uses external gate pin; it resets one, sync resets zero.
`default_nettype none

package cmp_ctrl_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [31:0] CONFIG_OFFSET = 32'h0000_0000;
	localparam logic [31:0] TIMER_CFG_OFFSET = 32'h0000_0004;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int SECOND_OUT_BIT = 7;
	localparam int FIRST_OUT_BIT = 6;
	localparam int SECOND_INV_BIT = 5;
	localparam int FIRST_INV_BIT = 4;
	localparam int INPUT_SWITCH_BIT = 3;
	localparam int MODE_LSB = 0;
	localparam int MODE_WIDTH = 3;
	localparam int GATE_SEL_BIT = 1;
	localparam int SYNC_BIT = 0;

	// ****************************************
	// Reset values and codes
	// ****************************************
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic GATE_SEL_RESET = 1'h1;
	localparam logic SYNC_RESET = 1'h0;
	localparam logic [2:0] MODE_OFF = 3'h7;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;
	localparam logic HRESP_OKAY = 1'h0;

	typedef enum logic [1:0] {
		sel_none_t,
		sel_config_t,
		sel_timer_cfg_t
	} reg_sel_t;

endpackage

`default_nettype wire

// ==== logic/level_sync.sv ====
// Purpose: Two-stage synchroniser for a group of asynchronous levels
// Assumes: Inputs come from pins or analog outputs outside sys_clk
// Notes: First stage is read by the second stage only
`default_nettype none

module level_sync #(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	// ****************************************
	// Synchroniser chain
	// ****************************************
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic stage1;
			always_ff @(posedge sys_clk) begin
				if (!nrst) begin
					stage1 <= 1'b0;
					sync_out[i] <= 1'b0;
				end else if (ce) begin
					stage1 <= async_in[i];
					sync_out[i] <= stage1;
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// ==== verification/cmp_ctrl_monitor.sv ====
// Purpose: Port checks of the dual comparator control block
// Assumes: Checks pause while ce is low; second comparator gates the timer
// Notes: Bound to the top module by name
`default_nettype none

module cmp_ctrl_monitor (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [2:0] cmp_mode_field,
	input wire logic cmp_enable,
	input wire logic cmp_pins_analog,
	input wire logic first_cmp_output,
	input wire logic second_cmp_output,
	input wire logic timer_clk,
	input wire logic external_gate_pin,
	input wire logic timer_on,
	input wire logic gate_enable,
	input wire logic timer_count_enable,
	input wire logic timer_gate_source_sel,
	input wire logic cmp_output_sync
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst || !ce);
	// ****************************************
	// Checks
	// ****************************************
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	mode_off_a: assert property ($stable(cmp_mode_field) [*2] |->
		cmp_enable == (cmp_mode_field != 3'h7) && cmp_pins_analog == cmp_enable)
		else $error("enable does not follow mode");
	off_zero_a: assert property (!cmp_enable [*2] |-> !first_cmp_output && !second_cmp_output)
		else $error("outputs not cleared while off");
	timer_off_a: assert property (!timer_on [*2] |-> !timer_count_enable)
		else $error("count enable while timer off");
	no_gate_a: assert property ((timer_on && !gate_enable) [*2] |-> timer_count_enable)
		else $error("count held off without gating");
	ext_gate_a: assert property ((timer_on && gate_enable && timer_gate_source_sel
		&& $stable(external_gate_pin)) [*5] |-> timer_count_enable == external_gate_pin)
		else $error("gate does not follow pin");
	cmp_gate_a: assert property ((timer_on && gate_enable && !timer_gate_source_sel
		&& !cmp_output_sync && $stable(second_cmp_output)) [*3] |->
		timer_count_enable == second_cmp_output)
		else $error("gate does not follow comparator");
	sync_hold_a: assert property ((timer_on && gate_enable && !timer_gate_source_sel
		&& cmp_output_sync && $stable(timer_clk)) [*8] |-> $stable(timer_count_enable))
		else $error("latched gate moved without timer clock");
	off_c: cover property (!cmp_enable);
	cmp_gate_c: cover property (timer_count_enable && !timer_gate_source_sel);
	sync_gate_c: cover property (timer_count_enable && cmp_output_sync);
endmodule

bind dual_comparator_control cmp_ctrl_monitor i_cmp_ctrl_monitor (.*);

`default_nettype wire

// ==== verification/cmp_analog_model.sv ====
// Purpose: Analog comparators and timer clock source
// Assumes: Levels are plain codes, never equal
// Notes: Timer clock stands still while clk_run is low
`default_nettype none

module cmp_analog_model (
	input wire logic [7:0] first_plus,
	input wire logic [7:0] first_minus,
	input wire logic [7:0] second_plus,
	input wire logic [7:0] second_minus,
	input wire logic clk_run,
	output logic first_cmp_raw,
	output logic second_cmp_raw,
	output logic timer_clk
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****************************************
	// Comparators and timer clock
	// ****************************************
	assign first_cmp_raw = first_plus > first_minus;
	assign second_cmp_raw = second_plus > second_minus;
	initial timer_clk = 1'b0;
	always begin
		#17;
		if (clk_run)
			timer_clk = !timer_clk;
	end
endmodule

`default_nettype wire

// ==== verification/testbench.sv ====
// Purpose: Self-checking bench of the dual comparator control block
// Assumes: Zero-wait slave, three edge status latency
// Notes: Expected values come from the integer model below
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, q, seed = 32'h14847622;
	logic [7:0] p1 = 8'h01, p2 = 8'h01, ref_lvl = 8'h80;
	logic run = 1'b0, timer_on = 1'b0, gate_enable = 1'b0, ext_pin = 1'b0, ce = 1'b1;
	logic hreadyout, hresp, f_out, s_out, tce, gss, sync_bit, tclk, r1, r2, en, isw;
	logic [2:0] mode;
	int o1, o2, error_cnt = 0, checks = 0;
	always #2.5 sys_clk = !sys_clk;
	dual_comparator_control i_dual_comparator_control (.sys_clk(sys_clk), .nrst(nrst),
		.ce(ce), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .first_cmp_raw(r1), .second_cmp_raw(r2),
		.cmp_mode_field(mode), .input_switch_sel(isw), .cmp_enable(en), .cmp_pins_analog(),
		.first_cmp_output(f_out), .second_cmp_output(s_out), .timer_clk(tclk),
		.external_gate_pin(ext_pin), .timer_on(timer_on), .gate_enable(gate_enable),
		.timer_count_enable(tce), .timer_gate_source_sel(gss), .cmp_output_sync(sync_bit));
	cmp_analog_model i_cmp_analog_model (.first_plus(p1), .first_minus(ref_lvl),
		.second_plus(p2), .second_minus(ref_lvl), .clk_run(run), .first_cmp_raw(r1),
		.second_cmp_raw(r2), .timer_clk(tclk));
	// ****************************************
	// Tasks
	// ****************************************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		if (error_cnt == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
		haddr <= a;
		hwrite <= w;
		htrans <= cmp_ctrl_pkg::HTRANS_NONSEQ;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic settle();
		repeat (8) @(posedge sys_clk);
	endtask
	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		#100000;
		error_cnt++;
		close_out();
	end
	initial begin
		repeat (3) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		chk({gss, sync_bit}, 2'h2);
		bus(cmp_ctrl_pkg::CONFIG_OFFSET, 1'b0, 32'h0);
		chk(q, 32'h0);
		bus(cmp_ctrl_pkg::TIMER_CFG_OFFSET, 1'b0, 32'h0);
		chk(q, 32'h2);
		bus(32'h0000_0008, 1'b1, 32'hFF);
		bus(32'h0000_0008, 1'b0, 32'h0);
		chk(q, 32'h0);
		for (int i = 0; i < 16; i++) begin
			seed = lfsr(seed);
			p1 <= {seed[7:1], 1'b1};
			p2 <= {seed[15:9], 1'b1};
			bus(cmp_ctrl_pkg::CONFIG_OFFSET, 1'b1, {seed[31:8], 2'h3, seed[18:16], i[2:0]});
			settle();
			o1 = (i % 8 != 7) && (seed[17] != seed[7]);
			o2 = (i % 8 != 7) && (seed[18] != seed[15]);
			bus(cmp_ctrl_pkg::CONFIG_OFFSET, 1'b0, 32'h0);
			chk(q, {o2[0], o1[0], seed[18:16], i[2:0]});
			chk({en, s_out, f_out, isw, mode}, {i % 8 != 7, o2[0], o1[0], seed[16], i[2:0]});
		end
		bus(cmp_ctrl_pkg::CONFIG_OFFSET, 1'b1, 32'h0);
		p2 <= 8'h01;
		gate_enable <= 1'b1;
		settle();
		chk(tce, 1'b0);
		timer_on <= 1'b1;
		gate_enable <= 1'b0;
		settle();
		chk(tce, 1'b1);
		gate_enable <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			ext_pin <= k[0];
			settle();
			chk(tce, k[0]);
		end
		ce <= 1'b0;
		ext_pin <= 1'b0;
		settle();
		chk(tce, 1'b1);
		ce <= 1'b1;
		settle();
		chk(tce, 1'b0);
		bus(cmp_ctrl_pkg::TIMER_CFG_OFFSET, 1'b1, 32'h0);
		settle();
		chk(tce, 1'b0);
		p2 <= 8'hF1;
		settle();
		chk(tce, 1'b1);
		bus(cmp_ctrl_pkg::TIMER_CFG_OFFSET, 1'b1, 32'h1);
		run <= 1'b1;
		repeat (40) @(posedge sys_clk);
		@(negedge tclk);
		run <= 1'b0;
		settle();
		p2 <= 8'h01;
		repeat (12) @(posedge sys_clk);
		chk(tce, 1'b1);
		run <= 1'b1;
		@(posedge tclk);
		run <= 1'b0;
		settle();
		chk(tce, 1'b1);
		run <= 1'b1;
		@(negedge tclk);
		run <= 1'b0;
		settle();
		chk(tce, 1'b0);
		close_out();
	end
endmodule

`default_nettype wire
